// file: core/host_uart_pkg.sv
package host_uart_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned BAUD_HZ = 115_200;
  localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_HZ;
  localparam int unsigned HALF_CYCLES = BIT_CYCLES / 2;
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned CNT_W = 16;
  localparam logic [CNT_W-1:0] BIT_CNT = CNT_W'(BIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] HALF_CNT = CNT_W'(HALF_CYCLES - 1);
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic LINE_IDLE = 1'b1;
  localparam logic FLOW_STOP = 1'b1;
  localparam logic FLOW_GO = 1'b0;
  typedef enum logic [1:0] {S_IDLE, S_START, S_DATA, S_STOP} uart_state_t;
endpackage

// file: core/host_uart_if.sv
`timescale 1ns/1ns
interface host_uart_if;
  logic host_tx_line;
  logic host_rx_line;
  logic host_clear_to_send_n;
  logic host_ready_to_send_n;
  modport device (
    output host_tx_line,
    input host_rx_line,
    input host_clear_to_send_n,
    output host_ready_to_send_n
  );
  modport host (
    input host_tx_line,
    output host_rx_line,
    output host_clear_to_send_n,
    input host_ready_to_send_n
  );
endinterface

// file: core/host_uart_device.sv
// Contract
// - Device sends async characters on tx line
// - Host sends characters; device recovers without clock
// - Clear-to-send only heeded with flow control
// - Clear-to-send low lets device transmit
// - Clear-to-send high blocks new character starts
// - Sample clear-to-send at frame start only
// - Ready-to-send meaningful only with flow control
// - Ready-to-send low means device accepts data
// - Ready-to-send high means receiver busy
`timescale 1ns/1ns
module host_uart_device
  import host_uart_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Control
  input wire logic i_flow_en,
  // Transmit data
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready,
  // Receive data
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  input wire logic i_rx_ready,
  // Serial side
  host_uart_if.device link
);
  import host_uart_pkg::*;

  // Pin synchronisers
  logic rx_s1_ff, rx_s2_ff, cts_s1_ff, cts_s2_ff;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_s1_ff <= LINE_IDLE;
      rx_s2_ff <= LINE_IDLE;
      cts_s1_ff <= FLOW_STOP;
      cts_s2_ff <= FLOW_STOP;
    end else begin
      rx_s1_ff <= link.host_rx_line;
      rx_s2_ff <= rx_s1_ff;
      cts_s1_ff <= link.host_clear_to_send_n;
      cts_s2_ff <= cts_s1_ff;
    end
  end

  // Transmitter
  uart_state_t tx_st_ff, nxt_tx_st;
  logic [CNT_W-1:0] tx_cnt_ff, nxt_tx_cnt;
  logic [3:0] tx_bit_ff, nxt_tx_bit;
  logic [7:0] tx_sh_ff, nxt_tx_sh;
  logic tx_line_ff, nxt_tx_line;
  logic tx_rdy_ff, nxt_tx_rdy;
  logic tx_go;

  always_comb begin
    // Ready carries the flow state, so a take never disagrees with it
    tx_go = !i_flow_en || (cts_s2_ff == FLOW_GO);
    nxt_tx_st = tx_st_ff;
    nxt_tx_cnt = tx_cnt_ff;
    nxt_tx_bit = tx_bit_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_tx_line = tx_line_ff;
    nxt_tx_rdy = tx_rdy_ff;
    unique case (tx_st_ff)
      S_IDLE: begin
        nxt_tx_line = LINE_IDLE;
        nxt_tx_rdy = tx_go;
        if (tx_rdy_ff && i_tx_valid) begin
          nxt_tx_sh = i_tx_data;
          nxt_tx_st = S_START;
          nxt_tx_cnt = BIT_CNT;
          nxt_tx_line = 1'b0;
          nxt_tx_rdy = 1'b0;
        end
      end
      S_START, S_DATA, S_STOP: begin
        // Mid-frame the clear-to-send input is ignored
        if (tx_cnt_ff != '0) begin
          nxt_tx_cnt = tx_cnt_ff - 1'b1;
        end else begin
          nxt_tx_cnt = BIT_CNT;
          if (tx_st_ff == S_START) begin
            nxt_tx_st = S_DATA;
            nxt_tx_bit = '0;
            nxt_tx_line = tx_sh_ff[0];
            nxt_tx_sh = {1'b0, tx_sh_ff[7:1]};
          end else if (tx_st_ff == S_DATA) begin
            if (tx_bit_ff == LAST_BIT) begin
              nxt_tx_st = S_STOP;
              nxt_tx_line = LINE_IDLE;
            end else begin
              nxt_tx_bit = tx_bit_ff + 1'b1;
              nxt_tx_line = tx_sh_ff[0];
              nxt_tx_sh = {1'b0, tx_sh_ff[7:1]};
            end
          end else begin
            nxt_tx_st = S_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_st_ff <= S_IDLE;
      tx_cnt_ff <= '0;
      tx_bit_ff <= '0;
      tx_sh_ff <= '0;
      tx_line_ff <= LINE_IDLE;
      tx_rdy_ff <= 1'b0;
    end else begin
      tx_st_ff <= nxt_tx_st;
      tx_cnt_ff <= nxt_tx_cnt;
      tx_bit_ff <= nxt_tx_bit;
      tx_sh_ff <= nxt_tx_sh;
      tx_line_ff <= nxt_tx_line;
      tx_rdy_ff <= nxt_tx_rdy;
    end
  end

  // Receiver with one-word holding register
  uart_state_t rx_st_ff, nxt_rx_st;
  logic [CNT_W-1:0] rx_cnt_ff, nxt_rx_cnt;
  logic [3:0] rx_bit_ff, nxt_rx_bit;
  logic [7:0] rx_sh_ff, nxt_rx_sh;
  logic [7:0] rx_data_ff, nxt_rx_data;
  logic rx_vld_ff, nxt_rx_vld;
  logic rts_ff, nxt_rts;

  always_comb begin
    nxt_rx_st = rx_st_ff;
    nxt_rx_cnt = rx_cnt_ff;
    nxt_rx_bit = rx_bit_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_rx_data = rx_data_ff;
    nxt_rx_vld = rx_vld_ff;
    if (rx_vld_ff && i_rx_ready) begin
      nxt_rx_vld = 1'b0;
    end
    unique case (rx_st_ff)
      S_IDLE: begin
        if (!rx_s2_ff) begin
          nxt_rx_st = S_START;
          nxt_rx_cnt = HALF_CNT;
        end
      end
      S_START: begin
        if (rx_cnt_ff != '0) begin
          nxt_rx_cnt = rx_cnt_ff - 1'b1;
        end else if (rx_s2_ff) begin
          nxt_rx_st = S_IDLE; // Glitch, not a start bit
        end else begin
          nxt_rx_st = S_DATA;
          nxt_rx_cnt = BIT_CNT;
          nxt_rx_bit = '0;
        end
      end
      S_DATA: begin
        if (rx_cnt_ff != '0) begin
          nxt_rx_cnt = rx_cnt_ff - 1'b1;
        end else begin
          nxt_rx_cnt = BIT_CNT;
          nxt_rx_sh = {rx_s2_ff, rx_sh_ff[7:1]};
          if (rx_bit_ff == LAST_BIT) begin
            nxt_rx_st = S_STOP;
          end else begin
            nxt_rx_bit = rx_bit_ff + 1'b1;
          end
        end
      end
      S_STOP: begin
        if (rx_cnt_ff != '0) begin
          nxt_rx_cnt = rx_cnt_ff - 1'b1;
        end else begin
          nxt_rx_st = S_IDLE;
          // Bad stop bit drops the character; overrun overwrites
          if (rx_s2_ff) begin
            nxt_rx_data = rx_sh_ff;
            nxt_rx_vld = 1'b1;
          end
        end
      end
    endcase
    // Busy as soon as the holding word is full; the shifter is the spare
    nxt_rts = FLOW_GO;
    if (i_flow_en && nxt_rx_vld) begin
      nxt_rts = FLOW_STOP;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_st_ff <= S_IDLE;
      rx_cnt_ff <= '0;
      rx_bit_ff <= '0;
      rx_sh_ff <= '0;
      rx_data_ff <= '0;
      rx_vld_ff <= 1'b0;
      rts_ff <= FLOW_STOP;
    end else begin
      rx_st_ff <= nxt_rx_st;
      rx_cnt_ff <= nxt_rx_cnt;
      rx_bit_ff <= nxt_rx_bit;
      rx_sh_ff <= nxt_rx_sh;
      rx_data_ff <= nxt_rx_data;
      rx_vld_ff <= nxt_rx_vld;
      rts_ff <= nxt_rts;
    end
  end

  assign link.host_tx_line = tx_line_ff;
  assign link.host_ready_to_send_n = rts_ff;
  assign o_tx_ready = tx_rdy_ff;
  assign o_rx_valid = rx_vld_ff;
  assign o_rx_data = rx_data_ff;
endmodule

// file: core/host_uart_host.sv
`timescale 1ns/1ns
module host_uart_host
  import host_uart_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Control
  input wire logic i_flow_en,
  input wire logic i_hold_off,
  // Transmit data
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready,
  // Receive data
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  // Serial side
  host_uart_if.host link
);
  import host_uart_pkg::*;

  logic rx_s1_ff, rx_s2_ff, rts_s1_ff, rts_s2_ff;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_s1_ff <= LINE_IDLE;
      rx_s2_ff <= LINE_IDLE;
      rts_s1_ff <= FLOW_STOP;
      rts_s2_ff <= FLOW_STOP;
    end else begin
      rx_s1_ff <= link.host_tx_line;
      rx_s2_ff <= rx_s1_ff;
      rts_s1_ff <= link.host_ready_to_send_n;
      rts_s2_ff <= rts_s1_ff;
    end
  end

  // Transmitter, bit counter counts start, 8 data, stop
  logic [CNT_W-1:0] tx_cnt_ff, nxt_tx_cnt;
  logic [3:0] tx_bit_ff, nxt_tx_bit;
  logic [9:0] tx_sh_ff, nxt_tx_sh;
  logic tx_busy_ff, nxt_tx_busy;
  logic tx_line_ff, nxt_tx_line;
  logic tx_rdy_ff, nxt_tx_rdy;
  logic cts_ff, nxt_cts;
  logic tx_go;

  always_comb begin
    tx_go = !i_flow_en || (rts_s2_ff == FLOW_GO);
    nxt_tx_cnt = tx_cnt_ff;
    nxt_tx_bit = tx_bit_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_tx_busy = tx_busy_ff;
    nxt_tx_line = tx_line_ff;
    nxt_tx_rdy = !tx_busy_ff && tx_go;
    nxt_cts = i_hold_off ? FLOW_STOP : FLOW_GO;
    if (!tx_busy_ff) begin
      nxt_tx_line = LINE_IDLE;
      // Take on ready alone; ready already holds the flow state
      if (tx_rdy_ff && i_tx_valid) begin
        nxt_tx_sh = {1'b1, i_tx_data, 1'b0};
        nxt_tx_line = 1'b0;
        nxt_tx_busy = 1'b1;
        nxt_tx_bit = '0;
        nxt_tx_cnt = BIT_CNT;
        nxt_tx_rdy = 1'b0;
      end
    end else if (tx_cnt_ff != '0) begin
      nxt_tx_cnt = tx_cnt_ff - 1'b1;
    end else if (tx_bit_ff == 4'h9) begin
      nxt_tx_busy = 1'b0;
    end else begin
      nxt_tx_cnt = BIT_CNT;
      nxt_tx_bit = tx_bit_ff + 1'b1;
      nxt_tx_sh = {1'b1, tx_sh_ff[9:1]};
      nxt_tx_line = tx_sh_ff[1];
    end
  end

  // Receiver
  uart_state_t rx_st_ff, nxt_rx_st;
  logic [CNT_W-1:0] rx_cnt_ff, nxt_rx_cnt;
  logic [3:0] rx_bit_ff, nxt_rx_bit;
  logic [7:0] rx_sh_ff, nxt_rx_sh;
  logic [7:0] rx_data_ff, nxt_rx_data;
  logic rx_vld_ff, nxt_rx_vld;

  always_comb begin
    nxt_rx_st = rx_st_ff;
    nxt_rx_cnt = rx_cnt_ff;
    nxt_rx_bit = rx_bit_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_rx_data = rx_data_ff;
    nxt_rx_vld = 1'b0;
    if (rx_cnt_ff != '0 && rx_st_ff != S_IDLE) begin
      nxt_rx_cnt = rx_cnt_ff - 1'b1;
    end else begin
      unique case (rx_st_ff)
        S_IDLE: begin
          if (!rx_s2_ff) begin
            nxt_rx_st = S_START;
            nxt_rx_cnt = HALF_CNT;
          end
        end
        S_START: begin
          nxt_rx_st = rx_s2_ff ? S_IDLE : S_DATA;
          nxt_rx_cnt = BIT_CNT;
          nxt_rx_bit = '0;
        end
        S_DATA: begin
          nxt_rx_cnt = BIT_CNT;
          nxt_rx_sh = {rx_s2_ff, rx_sh_ff[7:1]};
          if (rx_bit_ff == LAST_BIT) begin
            nxt_rx_st = S_STOP;
          end else begin
            nxt_rx_bit = rx_bit_ff + 1'b1;
          end
        end
        S_STOP: begin
          nxt_rx_st = S_IDLE;
          if (rx_s2_ff) begin
            nxt_rx_data = rx_sh_ff;
            nxt_rx_vld = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_cnt_ff <= '0;
      tx_bit_ff <= '0;
      tx_sh_ff <= '0;
      tx_busy_ff <= 1'b0;
      tx_line_ff <= LINE_IDLE;
      tx_rdy_ff <= 1'b0;
      cts_ff <= FLOW_STOP;
      rx_st_ff <= S_IDLE;
      rx_cnt_ff <= '0;
      rx_bit_ff <= '0;
      rx_sh_ff <= '0;
      rx_data_ff <= '0;
      rx_vld_ff <= 1'b0;
    end else begin
      tx_cnt_ff <= nxt_tx_cnt;
      tx_bit_ff <= nxt_tx_bit;
      tx_sh_ff <= nxt_tx_sh;
      tx_busy_ff <= nxt_tx_busy;
      tx_line_ff <= nxt_tx_line;
      tx_rdy_ff <= nxt_tx_rdy;
      cts_ff <= nxt_cts;
      rx_st_ff <= nxt_rx_st;
      rx_cnt_ff <= nxt_rx_cnt;
      rx_bit_ff <= nxt_rx_bit;
      rx_sh_ff <= nxt_rx_sh;
      rx_data_ff <= nxt_rx_data;
      rx_vld_ff <= nxt_rx_vld;
    end
  end

  assign link.host_rx_line = tx_line_ff;
  assign link.host_clear_to_send_n = cts_ff;
  assign o_tx_ready = tx_rdy_ff;
  assign o_rx_valid = rx_vld_ff;
  assign o_rx_data = rx_data_ff;
endmodule

// file: dv/host_uart_monitor.sv
`timescale 1ns/1ns
module host_uart_monitor (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Watched signals
  input wire logic i_flow_en,
  input wire logic host_tx_line,
  input wire logic host_rx_line,
  input wire logic host_clear_to_send_n,
  input wire logic host_ready_to_send_n
);
  import host_uart_pkg::*;
  localparam int HB = HALF_CYCLES;
  localparam int FRAME = 9 * BIT_CYCLES + HALF_CYCLES;
  // Index 0 is the device's line, 1 the host's
  logic [1:0] line;
  logic [1:0] q_ff;
  logic [1:0] start;
  logic [11:0] left_ff [2];
  logic [11:0] nxt_left [2];
  logic [7:0] run_ff [2];
  logic [7:0] nxt_run [2];
  assign line = {host_rx_line, host_tx_line};
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      start[i] = q_ff[i] && !line[i] && left_ff[i] == 12'h000;
      nxt_left[i] = left_ff[i] == 12'h000 ? 12'h000 : left_ff[i] - 12'h001;
      if (start[i]) begin
        nxt_left[i] = 12'(FRAME);
      end
      // Saturates so a long idle never wraps into a short run
      nxt_run[i] = run_ff[i] == 8'hff ? 8'hff : run_ff[i] + 8'h01;
      if (line[i] != q_ff[i]) begin
        nxt_run[i] = 8'h00;
      end
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q_ff <= 2'h3;
      left_ff <= '{default: 12'h000};
      run_ff <= '{default: 8'hff};
    end else begin
      q_ff <= line;
      left_ff <= nxt_left;
      run_ff <= nxt_run;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_tx_bit_width: assert property (
    line[0] != q_ff[0] |-> run_ff[0] >= 8'(BIT_CYCLES - 1))
    else $error("tx bit too short");
  a_rx_bit_width: assert property (
    line[1] != q_ff[1] |-> run_ff[1] >= 8'(BIT_CYCLES - 1))
    else $error("rx bit too short");
  a_tx_start_low: assert property (
    start[0] |-> ##HB !host_tx_line)
    else $error("tx start bit not low");
  a_rx_start_low: assert property (
    start[1] |-> ##HB !host_rx_line)
    else $error("rx start bit not low");
  a_tx_stop_high: assert property (
    left_ff[0] == 12'h001 |-> host_tx_line)
    else $error("tx stop bit not high");
  a_rx_stop_high: assert property (
    left_ff[1] == 12'h001 |-> host_rx_line)
    else $error("rx stop bit not high");
  a_cts_blocks_start: assert property (
    (i_flow_en && host_clear_to_send_n) [*5] |=> !start[0])
    else $error("tx frame started while blocked");
  a_rts_blocks_start: assert property (
    (i_flow_en && host_ready_to_send_n) [*5] |=> !start[1])
    else $error("rx frame started while blocked");
  a_rts_flow_off: assert property (
    (!i_flow_en) [*4] |-> !host_ready_to_send_n)
    else $error("ready line high with flow off");
  c_dev_frame: cover property (start[0]);
  c_host_frame: cover property (start[1]);
  c_cts_mid: cover property (left_ff[0] != 12'h000 && host_clear_to_send_n);
  c_rts_busy: cover property (i_flow_en && host_ready_to_send_n);
endmodule

// file: dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import host_uart_pkg::*;
  localparam int LIM = 5000;
  localparam logic [31:0] CORNERS = 32'h00ff0180;
  logic i_clk, i_rst_n, flow_en, hold_off, rx_ready;
  logic d_tx_valid, h_tx_valid, d_tx_ready, h_tx_ready;
  logic d_rx_valid, h_rx_valid;
  logic [7:0] d_tx_data, h_tx_data, d_rx_data, h_rx_data, seed, b1;
  int error_cnt;
  int cmp_count;
  host_uart_if link ();
  host_uart_device u_host_uart_device (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_flow_en(flow_en), .i_tx_valid(d_tx_valid), .i_tx_data(d_tx_data),
    .o_tx_ready(d_tx_ready), .o_rx_valid(d_rx_valid),
    .o_rx_data(d_rx_data), .i_rx_ready(rx_ready), .link(link));
  host_uart_host u_host_uart_host (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_flow_en(flow_en), .i_hold_off(hold_off), .i_tx_valid(h_tx_valid),
    .i_tx_data(h_tx_data), .o_tx_ready(h_tx_ready),
    .o_rx_valid(h_rx_valid), .o_rx_data(h_rx_data), .link(link));
  host_uart_monitor u_host_uart_monitor (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_flow_en(flow_en), .host_tx_line(link.host_tx_line),
    .host_rx_line(link.host_rx_line),
    .host_clear_to_send_n(link.host_clear_to_send_n),
    .host_ready_to_send_n(link.host_ready_to_send_n));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Busy is only signalled with flow control on
  function automatic logic [7:0] exp_rts(input logic flow, input logic held);
    return {7'h00, flow && held};
  endfunction
  function automatic logic sig(input int k);
    case (k)
      0: return d_tx_ready;
      1: return h_tx_ready;
      2: return d_rx_valid;
      default: return h_rx_valid;
    endcase
  endfunction
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      error_cnt++;
    end
  endtask
  task automatic wait_for(input int k);
    int n;
    n = 0;
    @(posedge i_clk);
    while (sig(k) !== 1'b1) begin
      n++;
      if (n > LIM) begin
        $display("unexpected wait %0d: expected 1, seen 0", k);
        error_cnt++;
        conclude();
      end
      @(posedge i_clk);
    end
  endtask
  task automatic xfer(input logic dir, input logic [7:0] b);
    if (dir) begin
      h_tx_data <= b;
      h_tx_valid <= 1'b1;
      wait_for(1);
      h_tx_valid <= 1'b0;
    end else begin
      d_tx_data <= b;
      d_tx_valid <= 1'b1;
      wait_for(0);
      d_tx_valid <= 1'b0;
    end
    @(posedge i_clk);
  endtask
  task automatic expect_rx(input logic dir, input logic [7:0] b);
    wait_for(dir ? 2 : 3);
    check("rx byte", b, dir ? d_rx_data : h_rx_data);
  endtask
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  initial begin
    i_rst_n <= 1'b0;
    {flow_en, d_tx_valid, h_tx_valid, d_tx_data, h_tx_data} <= '0;
    hold_off <= 1'b1;
    rx_ready <= 1'b1;
    seed = 8'h28;
    error_cnt = 0;
    cmp_count = 0;
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    // Flow off, clear-to-send held high, traffic both ways
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      b1 = i < 4 ? CORNERS[8*i +: 8] : seed;
      fork
        begin
          xfer(1'b0, b1);
          expect_rx(1'b0, b1);
        end
        begin
          xfer(1'b1, ~b1);
          expect_rx(1'b1, ~b1);
        end
      join
    end
    check("rts", exp_rts(flow_en, 1'b1), link.host_ready_to_send_n);
    flow_en <= 1'b1;
    hold_off <= 1'b0;
    b1 = lfsr(seed);
    fork
      begin
        xfer(1'b0, b1);
        xfer(1'b0, ~b1);
      end
      begin
        repeat (400) @(posedge i_clk);
        hold_off <= 1'b1;
        expect_rx(1'b0, b1);
        repeat (600) @(posedge i_clk);
        check("tx line", 8'h01, {7'h00, link.host_tx_line});
        check("tx ready", 8'h00, {7'h00, d_tx_ready});
        hold_off <= 1'b0;
        expect_rx(1'b0, ~b1);
      end
    join
    // Receiver left full so the ready line must go busy
    rx_ready <= 1'b0;
    b1 = lfsr(b1);
    xfer(1'b1, b1);
    expect_rx(1'b1, b1);
    repeat (4) @(posedge i_clk);
    check("rts", exp_rts(flow_en, 1'b1), link.host_ready_to_send_n);
    fork
      xfer(1'b1, ~b1);
      begin
        repeat (600) @(posedge i_clk);
        check("rx line", 8'h01, {7'h00, link.host_rx_line});
        rx_ready <= 1'b1;
      end
    join
    expect_rx(1'b1, ~b1);
    conclude();
  end
endmodule
